// ### expander_link_defs.svh
`ifndef EXPANDER_LINK_DEFS_SVH
`define EXPANDER_LINK_DEFS_SVH

// ****************************************
// Widths and reset values
// ****************************************
`define PORT_W 24
`define OUT_RST 24'hFFFFFF
`define CFG_RST 24'hFFFFFF

// ****************************************
// Bus framing
// ****************************************
// Upper six address bits; strap supplies the lowest
`define ADDR_HI 6'h11
`define RW_READ 1'b1
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7

// ****************************************
// Register pointer: group in [3:2], port in [1:0]
// ****************************************
`define GRP_INPUT 2'h0
`define GRP_OUTPUT 2'h1
`define GRP_CONFIG 2'h3
`define PORT_LAST 2'h2

// ****************************************
// Glitch filter timing
// ****************************************
`define SPIKE_NS 50
`define LINK_PERIOD_NS 64
`define FILT_CYC (((`SPIKE_NS / `LINK_PERIOD_NS) < 1) ? 1 : \
    (`SPIKE_NS / `LINK_PERIOD_NS))

`endif

// ### expander_link_pkg.sv
`default_nettype none

package expander_link_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_WR_ACK = 3'b100,
        ST_READ = 3'b101,
        ST_RD_ACK = 3'b110,
        ST_IGNORE = 3'b111
    } link_state_e;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] reg_ptr_t;
endpackage : expander_link_pkg

`default_nettype wire

// ### i2c_expander_slave_link.sv
`include "expander_link_defs.svh"
`default_nettype none

module i2c_expander_slave_link (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_sel_i,
    input wire logic [`PORT_W-1:0] expander_io_pins_i,
    output logic [`PORT_W-1:0] expander_io_pins_o,
    output logic [`PORT_W-1:0] expander_io_pins_oe_o
);
    import expander_link_pkg::*;

    // ****************************************
    // Link-domain reset and enable
    // ****************************************
    logic [1:0] lrst_sync;
    logic [1:0] len_sync;
    logic link_rst_n;
    logic link_en;

    always_ff @(posedge link_clk_i) begin
        lrst_sync <= {lrst_sync[0], resetn_i};
        len_sync <= {len_sync[0], clk_en_i};
    end
    assign link_rst_n = lrst_sync[1];
    assign link_en = len_sync[1];

    // ****************************************
    // Line synchronisers and glitch filter
    // ****************************************
    wire [1:0] line_raw = {scl_i, sda_i};
    wire [1:0] line_filt;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_line
            logic [1:0] sync;
            logic [1:0] cnt;
            logic filt;
            // Level must persist past the spike time to be taken
            always_ff @(posedge link_clk_i) begin
                if (!link_rst_n) begin
                    sync <= 2'h3;
                    cnt <= 2'h0;
                    filt <= 1'b1;
                end else if (link_en) begin
                    sync <= {sync[0], line_raw[g]};
                    if (sync[1] == filt) begin
                        cnt <= 2'h0;
                    end else if (cnt == 2'(`FILT_CYC)) begin
                        filt <= sync[1];
                        cnt <= 2'h0;
                    end else begin
                        cnt <= cnt + 2'h1;
                    end
                end
            end
            assign line_filt[g] = filt;
        end
    endgenerate

    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    logic [1:0] strap_sync;
    assign scl_f = line_filt[1];
    assign sda_f = line_filt[0];

    always_ff @(posedge link_clk_i) begin
        if (!link_rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            strap_sync <= 2'h0;
        end else if (link_en) begin
            scl_q <= scl_f;
            sda_q <= sda_f;
            strap_sync <= {strap_sync[0], addr_sel_i};
        end
    end

    // ****************************************
    // Bus events
    // ****************************************
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic evt_ok;
    // Edges of data under a high clock are framing only
    assign start_det = link_en & scl_f & scl_q & sda_q & ~sda_f;
    assign stop_det = link_en & scl_f & scl_q & ~sda_q & sda_f;
    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign evt_ok = link_en & ~start_det & ~stop_det;

    // ****************************************
    // Bus state machine
    // ****************************************
    link_state_e state;
    logic [3:0] bitcnt;
    byte_t shift;
    byte_t rd_byte;
    logic rw;
    logic first_byte;
    logic sda_oe;
    logic strap_lat;
    logic byte_end;
    logic addr_hit;
    logic load_rd;

    assign byte_end = evt_ok & scl_fall & (bitcnt == `BYTE_BITS);
    assign addr_hit = byte_end & (state == ST_ADDR) &
        (shift[7:1] == {`ADDR_HI, strap_lat});
    assign load_rd = evt_ok & scl_fall & ((state == ST_RD_ACK) |
        ((state == ST_ADDR_ACK) & (rw == `RW_READ)));

    always_ff @(posedge link_clk_i) begin
        if (!link_rst_n) begin
            state <= ST_IDLE;
            bitcnt <= 4'h0;
            shift <= 8'h00;
            rw <= 1'b0;
            first_byte <= 1'b0;
            sda_oe <= 1'b0;
            strap_lat <= 1'b0;
        end else if (link_en) begin
            if (stop_det) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start_det) begin
                // Repeated start restarts from the address byte
                state <= ST_ADDR;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
                strap_lat <= strap_sync[1];
            end else if (load_rd) begin
                state <= ST_READ;
                shift <= rd_byte;
                sda_oe <= ~rd_byte[7];
                bitcnt <= 4'h0;
            end else begin
                case (state)
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_f};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (byte_end) begin
                            bitcnt <= 4'h0;
                            if (state == ST_WRITE) begin
                                state <= ST_WR_ACK;
                                sda_oe <= 1'b1;
                            end else if (addr_hit) begin
                                state <= ST_ADDR_ACK;
                                sda_oe <= 1'b1;
                                rw <= shift[0];
                            end else begin
                                state <= ST_IGNORE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            state <= ST_WRITE;
                            sda_oe <= 1'b0;
                            first_byte <= 1'b1;
                        end
                    end
                    ST_WR_ACK: begin
                        // Held low until the clock falls again
                        if (scl_fall) begin
                            state <= ST_WRITE;
                            sda_oe <= 1'b0;
                            first_byte <= 1'b0;
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            if (bitcnt == `LAST_BIT) begin
                                state <= ST_RD_ACK;
                                sda_oe <= 1'b0;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                sda_oe <= ~shift[6];
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    ST_RD_ACK: begin
                        if (scl_rise && sda_f) begin
                            state <= ST_IGNORE;
                        end
                    end
                    ST_IDLE, ST_IGNORE: begin
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe;

    // ****************************************
    // Register pointer and crossing requests
    // ****************************************
    function automatic reg_ptr_t next_ptr(input reg_ptr_t p);
        next_ptr = {p[3:2], (p[1:0] == `PORT_LAST) ? 2'h0 :
            p[1:0] + 2'h1};
    endfunction : next_ptr

    reg_ptr_t ptr;
    reg_ptr_t wr_idx;
    reg_ptr_t rd_idx;
    byte_t wr_data;
    logic wr_req_tgl;
    logic rd_req_tgl;
    logic [1:0] ack_sync;
    logic ack_q;
    byte_t rd_data_core;
    logic rd_ack_tgl;

    // Requests hold index and data until the next toggle, one bit later after an address match, else a byte later
    always_ff @(posedge link_clk_i) begin
        if (!link_rst_n) begin
            ptr <= 4'h0;
            wr_idx <= 4'h0;
            rd_idx <= 4'h0;
            wr_data <= 8'h00;
            wr_req_tgl <= 1'b0;
            rd_req_tgl <= 1'b0;
        end else if (link_en) begin
            if (addr_hit) begin
                rd_idx <= ptr;
                rd_req_tgl <= ~rd_req_tgl;
            end else if (load_rd) begin
                // Prefetch the next byte while this one goes out
                ptr <= rd_idx;
                rd_idx <= next_ptr(rd_idx);
                rd_req_tgl <= ~rd_req_tgl;
            end else if (byte_end && state == ST_WRITE) begin
                if (first_byte) begin
                    ptr <= shift[3:0];
                end else begin
                    wr_idx <= ptr;
                    wr_data <= shift;
                    wr_req_tgl <= ~wr_req_tgl;
                    ptr <= next_ptr(ptr);
                end
            end
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!link_rst_n) begin
            ack_sync <= 2'h0;
            ack_q <= 1'b0;
            rd_byte <= 8'h00;
        end else if (link_en) begin
            ack_sync <= {ack_sync[0], rd_ack_tgl};
            ack_q <= ack_sync[1];
            if (ack_sync[1] != ack_q) begin
                rd_byte <= rd_data_core;
            end
        end
    end

    // ****************************************
    // Core domain: port registers
    // ****************************************
    logic [1:0] wr_sync;
    logic [1:0] rd_sync;
    logic wr_q;
    logic rd_q;
    logic [`PORT_W-1:0] pin_s0;
    logic [`PORT_W-1:0] pin_s1;
    logic [`PORT_W-1:0] out_reg;
    logic [`PORT_W-1:0] cfg_reg;
    logic wr_ev;
    assign wr_ev = wr_sync[1] ^ wr_q;

    function automatic byte_t pick(input logic [`PORT_W-1:0] v,
            input logic [1:0] port);
        pick = (port > `PORT_LAST) ? 8'h00 : v[{port, 3'h0} +: 8];
    endfunction : pick

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            wr_sync <= 2'h0;
            rd_sync <= 2'h0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            pin_s0 <= '0;
            pin_s1 <= '0;
        end else if (clk_en_i) begin
            wr_sync <= {wr_sync[0], wr_req_tgl};
            rd_sync <= {rd_sync[0], rd_req_tgl};
            wr_q <= wr_sync[1];
            rd_q <= rd_sync[1];
            pin_s0 <= expander_io_pins_i;
            pin_s1 <= pin_s0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            out_reg <= `OUT_RST;
            cfg_reg <= `CFG_RST;
        end else if (clk_en_i && wr_ev && wr_idx[1:0] <= `PORT_LAST) begin
            if (wr_idx[3:2] == `GRP_OUTPUT) begin
                out_reg[{wr_idx[1:0], 3'h0} +: 8] <= wr_data;
            end else if (wr_idx[3:2] == `GRP_CONFIG) begin
                cfg_reg[{wr_idx[1:0], 3'h0} +: 8] <= wr_data;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            rd_data_core <= 8'h00;
            rd_ack_tgl <= 1'b0;
        end else if (clk_en_i && (rd_sync[1] ^ rd_q)) begin
            case (rd_idx[3:2])
                `GRP_INPUT: rd_data_core <= pick(pin_s1, rd_idx[1:0]);
                `GRP_OUTPUT: rd_data_core <= pick(out_reg, rd_idx[1:0]);
                `GRP_CONFIG: rd_data_core <= pick(cfg_reg, rd_idx[1:0]);
                default: rd_data_core <= 8'h00;
            endcase
            rd_ack_tgl <= ~rd_ack_tgl;
        end
    end

    // Set bit turns the pin driver off; clear drives the output bit
    assign expander_io_pins_oe_o = ~cfg_reg;
    assign expander_io_pins_o = out_reg;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_addr_done_miss;
        byte_end && state == ST_ADDR && !addr_hit;
    endsequence

    sequence s_write_done;
        byte_end && state == ST_WRITE;
    endsequence

    a_start_addr:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            start_det |=> state == ST_ADDR && !sda_oe)
        else $error("start not taken");
    a_addr_shift:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            evt_ok && state == ST_ADDR && scl_rise |=>
            shift[0] == $past(sda_f) && bitcnt == $past(bitcnt) + 4'h1)
        else $error("address bit not shifted");
    a_addr_ack:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            addr_hit |=> state == ST_ADDR_ACK && sda_oe)
        else $error("address not acknowledged");
    a_miss_quiet:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            s_addr_done_miss |=> (state == ST_IGNORE && !sda_oe) [*2])
        else $error("foreign address answered");
    a_high_edge:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            link_en && scl_f && scl_q && sda_f != sda_q |=>
            state == ST_ADDR || state == ST_IDLE)
        else $error("high-clock edge taken as data");
    a_stop_idle:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            stop_det |=> state == ST_IDLE && !sda_oe)
        else $error("stop not honoured");
    a_write_ack:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            s_write_done |=> state == ST_WR_ACK && sda_oe)
        else $error("written byte not acknowledged");
    a_ack_hold:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            (state == ST_WR_ACK || state == ST_ADDR_ACK) |-> sda_oe)
        else $error("acknowledge released early");
    a_rd_release:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            (state == ST_RD_ACK || state == ST_IGNORE) |-> !sda_oe)
        else $error("line driven in master slot");
    a_read_load:
        assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
            load_rd |=> state == ST_READ && sda_oe == !$past(rd_byte[7]))
        else $error("read byte not loaded");
    a_fsm_reset:
        assert property (@(posedge link_clk_i)
            !link_rst_n |=> state == ST_IDLE && !sda_oe)
        else $error("bus state not reset");
    a_pins_reset:
        assert property (@(posedge core_clk_i)
            !resetn_i |=> expander_io_pins_oe_o == '0 &&
            expander_io_pins_o == `OUT_RST)
        else $error("pins not reset to inputs");
    a_out_write:
        assert property (@(posedge core_clk_i) disable iff (!resetn_i)
            clk_en_i && wr_ev && wr_idx == {`GRP_OUTPUT, 2'h0} |=>
            expander_io_pins_o[7:0] == $past(wr_data))
        else $error("output write lost");
    a_input_hiz:
        assert property (@(posedge core_clk_i) disable iff (!resetn_i)
            (expander_io_pins_oe_o & cfg_reg) == '0)
        else $error("input pin driven");

endmodule : i2c_expander_slave_link

`default_nettype wire

// ### i2c_master_model.sv
`default_nettype none

module i2c_master_model (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import expander_link_pkg::*;

    // ****************************************
    // Bus phases
    // ****************************************
    // Slow half period keeps room for the device's cross-domain fetch
    localparam int HALF = 1280;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // Data moves an eighth of a period after the fall, clear of the clock edge
    task automatic bit_io(input logic b, output logic s);
        #(HALF / 4) sda_low_o = ~b;
        #(HALF * 3 / 4) scl_o = 1'b1;
        #(HALF / 2) s = sda_i;
        #(HALF / 2) scl_o = 1'b0;
    endtask : bit_io

    task automatic start();
        #(HALF / 4) sda_low_o = 1'b0;
        #HALF scl_o = 1'b1;
        #HALF sda_low_o = 1'b1;
        #HALF scl_o = 1'b0;
    endtask : start

    task automatic stop();
        #(HALF / 4) sda_low_o = 1'b1;
        #HALF scl_o = 1'b1;
        #HALF sda_low_o = 1'b0;
        #HALF;
    endtask : stop

    task automatic write_bits(input byte_t d, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--) begin
            bit_io(d[i], s);
        end
    endtask : write_bits

    task automatic write_byte(input byte_t d, output logic ack);
        logic s;
        write_bits(d, 8);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : write_byte

    task automatic read_byte(input logic ack, output byte_t d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~ack, s);
    endtask : read_byte
endmodule : i2c_master_model

`default_nettype wire

// ### tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import expander_link_pkg::*;

    // ****************************************
    // Clocks, wires and counters
    // ****************************************
    logic core_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic addr_sel_i = 1'b0;
    logic [23:0] pins_in = 24'hC3B2A1;
    logic sda_o;
    logic sda_oe_o;
    logic [23:0] pins_o;
    logic [23:0] pins_oe_o;
    logic scl;
    logic m_low;
    logic sda_line;
    int failures = 0;
    int checked = 0;

    // Pull-up wins unless someone pulls low
    assign sda_line = ~(m_low | (sda_oe_o & ~sda_o));

    always #20 core_clk_i = ~core_clk_i;
    always #32 link_clk_i = ~link_clk_i;

    i2c_expander_slave_link i2c_expander_slave_link_i (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .link_clk_i(link_clk_i),
        .scl_i(scl),
        .sda_i(sda_line),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .addr_sel_i(addr_sel_i),
        .expander_io_pins_i(pins_in),
        .expander_io_pins_o(pins_o),
        .expander_io_pins_oe_o(pins_oe_o)
    );

    i2c_master_model i2c_master_model_i (
        .scl_o(scl),
        .sda_low_o(m_low),
        .sda_i(sda_line)
    );

    // ****************************************
    // Compare and helper tasks
    // ****************************************
    task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_byte(input byte_t got, input byte_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic core_wait(input int n);
        repeat (n) @(posedge core_clk_i);
        #2;
    endtask : core_wait

    // Eight core cycles also cover five link rising edges
    task automatic reset_dut();
        core_wait(1);
        resetn_i = 1'b0;
        core_wait(8);
        resetn_i = 1'b1;
        core_wait(30);
    endtask : reset_dut

    task automatic send(input byte_t d, input logic exp_ack);
        logic ack;
        i2c_master_model_i.write_byte(d, ack);
        check_bit(ack, exp_ack);
    endtask : send

    task automatic fetch(input logic ack, input byte_t exp);
        byte_t d;
        i2c_master_model_i.read_byte(ack, d);
        check_byte(d, exp);
    endtask : fetch

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset_state();
        check_word(pins_oe_o, 24'h000000);
        check_word(pins_o, 24'hFFFFFF);
        check_bit(sda_oe_o, 1'b0);
    endtask : test_reset_state

    // Four bytes into a group of three: the fourth wraps to port 0
    task automatic test_config_write();
        i2c_master_model_i.start();
        send(8'h44, 1'b1);
        send(8'h0C, 1'b1);
        send(8'h00, 1'b1);
        send(8'hF0, 1'b1);
        send(8'h0F, 1'b1);
        send(8'hA5, 1'b1);
        i2c_master_model_i.stop();
        core_wait(20);
        check_word(pins_oe_o, 24'hF00F5A);
        check_word(pins_o, 24'hFFFFFF);
    endtask : test_config_write

    task automatic test_output_rw();
        i2c_master_model_i.start();
        send(8'h44, 1'b1);
        send(8'h06, 1'b1);
        send(8'h56, 1'b1);
        send(8'h12, 1'b1);
        send(8'h34, 1'b1);
        i2c_master_model_i.stop();
        core_wait(20);
        check_word(pins_o, 24'h563412);
        i2c_master_model_i.start();
        send(8'h44, 1'b1);
        send(8'h04, 1'b1);
        i2c_master_model_i.start();
        send(8'h45, 1'b1);
        fetch(1'b1, 8'h12);
        fetch(1'b1, 8'h34);
        fetch(1'b0, 8'h56);
        core_wait(10);
        check_bit(sda_oe_o, 1'b0);
        i2c_master_model_i.stop();
    endtask : test_output_rw

    task automatic test_input_read();
        i2c_master_model_i.start();
        send(8'h44, 1'b1);
        send(8'h00, 1'b1);
        i2c_master_model_i.start();
        send(8'h45, 1'b1);
        fetch(1'b1, 8'hA1);
        fetch(1'b0, 8'hB2);
        i2c_master_model_i.stop();
    endtask : test_input_read

    // Strap only moves while the bus is idle
    task automatic test_address();
        i2c_master_model_i.start();
        send(8'h46, 1'b0);
        send(8'h00, 1'b0);
        i2c_master_model_i.stop();
        core_wait(1);
        addr_sel_i = 1'b1;
        i2c_master_model_i.start();
        send(8'h44, 1'b0);
        i2c_master_model_i.start();
        send(8'h46, 1'b1);
        i2c_master_model_i.stop();
        core_wait(1);
        addr_sel_i = 1'b0;
    endtask : test_address

    // A byte cut short by Stop must not land
    task automatic test_partial_byte();
        i2c_master_model_i.start();
        send(8'h44, 1'b1);
        send(8'h04, 1'b1);
        i2c_master_model_i.write_bits(8'h00, 4);
        i2c_master_model_i.stop();
        core_wait(20);
        check_word(pins_o, 24'h563412);
    endtask : test_partial_byte

    task automatic test_clk_en();
        core_wait(1);
        clk_en_i = 1'b0;
        i2c_master_model_i.start();
        send(8'h44, 1'b0);
        core_wait(1);
        clk_en_i = 1'b1;
        core_wait(10);
        i2c_master_model_i.stop();
    endtask : test_clk_en

    task automatic test_midrun_reset();
        reset_dut();
        check_word(pins_oe_o, 24'h000000);
        check_word(pins_o, 24'hFFFFFF);
    endtask : test_midrun_reset

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        reset_dut();
        test_reset_state();
        test_config_write();
        test_output_rw();
        test_input_read();
        test_address();
        test_partial_byte();
        test_clk_en();
        test_midrun_reset();
        test_done();
    end

    // Whole run is well under three milliseconds
    initial begin
        #3000000;
        failures++;
        test_done();
    end
endmodule : tb

`default_nettype wire
